// [hdl/timer_unit_zero_defs.svh]
// Register offsets, field positions, reset values and mode codes of the timer unit
`ifndef TIMER_UNIT_ZERO_DEFS_SVH
`define TIMER_UNIT_ZERO_DEFS_SVH

// Byte offsets on the register bus
`define OFS_CONTROL_A   4'h0
`define OFS_CONTROL_B   4'h1
`define OFS_CONTROL_C   4'h2
`define OFS_COUNT       4'h3
`define OFS_COMPARE_A   4'h4
`define OFS_COMPARE_B   4'h5
`define OFS_FLAG        4'h6
`define OFS_MASK        4'h7
`define OFS_POWER       4'h8

// Control A fields
`define FLD_WGM_LO      1:0
`define FLD_ACT_B       5:4
`define FLD_ACT_A       7:6
// Control B fields
`define FLD_CS          2:0
`define BIT_WGM_HI      3
// Control C fields
`define BIT_FORCE_B     6
`define BIT_FORCE_A     7
// Flag and mask bit positions
`define BIT_OVF         0
`define BIT_MATCH_A     1
`define BIT_MATCH_B     2
// Power bit position
`define BIT_POWER_OFF   0

// Counter extremes
`define COUNT_BOTTOM    8'h00
`define COUNT_MAX       8'hff
`define RESET_BYTE      8'h00

// Clock select codes
`define CS_STOPPED      3'h0
`define CS_DIV1         3'h1
`define CS_DIV8         3'h2
`define CS_DIV64        3'h3
`define CS_DIV256       3'h4
`define CS_DIV1024      3'h5
`define CS_EXT_FALL     3'h6
`define CS_EXT_RISE     3'h7

// Wave mode codes
`define WGM_NORMAL      3'h0
`define WGM_PHASE_MAX   3'h1
`define WGM_CTC         3'h2
`define WGM_FAST_MAX    3'h3
`define WGM_PHASE_A     3'h5
`define WGM_FAST_A      3'h7

// Output action codes
`define ACT_NONE        2'h0
`define ACT_TOGGLE      2'h1
`define ACT_CLEAR       2'h2
`define ACT_SET         2'h3

`endif

// [hdl/timer_unit_zero_pkg.sv]
// Types shared by the timer unit files
package timer_unit_zero_pkg;
	typedef enum logic [1:0] {
		BUS_IDLE,
		BUS_READ,
		BUS_DONE
	} bus_state_e;
endpackage

// [hdl/tick_select.sv]
// Clock select and prescaler producing the one-cycle timer tick
`timescale 1ns/100ps
`include "timer_unit_zero_defs.svh"

module tick_select #(
	parameter int PRESCALE_WIDTH = 10
) (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       arst_n,
	// Control
	input  wire logic       run,
	input  wire logic [2:0] clock_select_field,
	input  wire logic       ext_count_pin,
	// Tick out
	output logic            timer_tick
);
	// Divide by 1024 needs ten prescaler bits, refused at elaboration
	if (PRESCALE_WIDTH < 10) begin : g_width_check
		$error("prescaler too narrow for divide by 1024");
	end

	logic [PRESCALE_WIDTH-1:0] prescale_reg;
	logic [PRESCALE_WIDTH-1:0] prescale_next;
	logic                      pin_sync1_reg;
	logic                      pin_sync2_reg;
	logic                      pin_last_reg;
	logic                      tick_reg;
	logic                      tick_next;

	// Free-running prescaler, halted while powered down
	always_comb begin
		prescale_next = run ? prescale_reg + 1'b1 : prescale_reg;
	end

	// Source and edge choice; zero code yields no tick
	always_comb begin
		tick_next = 1'b0;
		if (run) begin
			case (clock_select_field)
				`CS_STOPPED:  tick_next = 1'b0;
				`CS_DIV1:     tick_next = 1'b1;
				`CS_DIV8:     tick_next = &prescale_reg[2:0];
				`CS_DIV64:    tick_next = &prescale_reg[5:0];
				`CS_DIV256:   tick_next = &prescale_reg[7:0];
				`CS_DIV1024:  tick_next = &prescale_reg[9:0];
				`CS_EXT_FALL: tick_next = pin_last_reg & ~pin_sync2_reg;
				`CS_EXT_RISE: tick_next = ~pin_last_reg & pin_sync2_reg;
				default:      tick_next = 1'b0;
			endcase
		end
	end

	// Pin synchronised first; edge detect reads only the second stage and its delayed copy
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			prescale_reg  <= '0;
			pin_sync1_reg <= 1'b0;
			pin_sync2_reg <= 1'b0;
			pin_last_reg  <= 1'b0;
			tick_reg      <= 1'b0;
		end else begin
			prescale_reg  <= prescale_next;
			pin_sync1_reg <= ext_count_pin;
			pin_sync2_reg <= pin_sync1_reg;
			pin_last_reg  <= pin_sync2_reg;
			tick_reg      <= tick_next;
		end
	end

	assign timer_tick = tick_reg;
endmodule

// [hdl/timer_unit_zero.sv]
// 8-bit timer/counter with two compare units behind an Avalon-MM slave
// Function
// - Count and both compare values are eight bits wide.
// - Value zero is the bottom of the range.
// - Value 255 is the maximum of the range.
// - Top is 255 or compare A, chosen by the mode.
// - Flags read in one register, each request gated by a mask bit.
// - Tick comes from prescaler or external pin, source and edge selected.
// - Clock select zero gives no tick; counter stays stopped.
// - Each tick clears, increments or decrements the counter per mode.
// - Counter always readable and writable; a write beats clear or count.
// - Three-bit mode field, low two bits in control A, high in B.
// - Overflow flag set where mode defines, may request an interrupt.
// - Counter compared to both compares; match sets flag on next tick.
// - Compare flag clears when serviced or when one is written.
// - PWM modes write a buffer, copied at top only.
// - Normal and clear-on-match modes access the compare directly.
// - Force strobe in non-PWM modes acts on output, not flag or counter.
// - A counter write blocks match flags and outputs in the next tick; clear-on-match still clears the counter.
// - Output states keep their values across mode changes.
// - Output action bits act immediately, unbuffered.
// - Normal mode counts up, wraps to zero, flags overflow at zero.
// - Clear-on-match mode clears counter on compare A match.
// - Fast PWM counts up to 255 (code 3) or compare A (code 7).
// - Action field zero leaves output state unchanged on match.
`timescale 1ns/100ps
`include "timer_unit_zero_defs.svh"

module timer_unit_zero #(
	parameter int PRESCALE_WIDTH = 10
) (
	// Clock and reset
	input  wire logic       CLK_IN,
	input  wire logic       ARST_N_IN,
	// Avalon-MM slave
	input  wire logic [3:0] ADDRESS_IN,
	input  wire logic       READ_IN,
	input  wire logic       WRITE_IN,
	input  wire logic [7:0] WRITEDATA_IN,
	output logic [7:0]      READDATA_OUT,
	output logic            WAITREQUEST_OUT,
	// Pins
	input  wire logic       EXT_COUNT_PIN_IN,
	output logic            COMPARE_OUT_A_OUT,
	output logic            COMPARE_OUT_B_OUT,
	// Interrupt requests and acknowledges
	output logic            IRQ_OVF_OUT,
	output logic            IRQ_MATCH_A_OUT,
	output logic            IRQ_MATCH_B_OUT,
	input  wire logic       ACK_OVF_IN,
	input  wire logic       ACK_MATCH_A_IN,
	input  wire logic       ACK_MATCH_B_IN
);
	// Mode decode used in several places
	function automatic logic is_pwm(input logic [2:0] m);
		return (m == `WGM_PHASE_MAX) || (m == `WGM_FAST_MAX) ||
			(m == `WGM_PHASE_A) || (m == `WGM_FAST_A);
	endfunction

	// Next output state of one unit; the top bit says whether an action applies
	function automatic logic [1:0] out_action(input logic [1:0] act, input logic st);
		case (act)
			`ACT_TOGGLE: return {1'b1, ~st};
			`ACT_CLEAR:  return {1'b1, 1'b0};
			`ACT_SET:    return {1'b1, 1'b1};
			default:     return {1'b0, st};
		endcase
	endfunction

	// Bus handshake and configuration registers
	timer_unit_zero_pkg::bus_state_e bus_reg, bus_next;
	logic [7:0] control_reg_a, control_a_next;
	logic [7:0] control_reg_b, control_b_next;

	// Counter, live compares and their PWM buffers
	logic [7:0] count_reg, count_next;
	logic [7:0] compare_a_reg, compare_a_next;
	logic [7:0] compare_b_reg, compare_b_next;
	logic [7:0] buffer_a_reg, buffer_a_next;
	logic [7:0] buffer_b_reg, buffer_b_next;

	// Flags, masks and power-off
	logic [2:0] flag_reg, flag_next;
	logic [2:0] mask_reg, mask_next;
	logic       power_off_reg, power_off_next;

	// Output states, match blocking, slope direction, read data and requests
	logic [1:0] state_reg, state_next;
	logic       block_reg, block_next;
	logic       down_reg, down_next;
	logic [7:0] rdata_reg, rdata_next;
	logic [2:0] irq_reg, irq_next;

	// Decode of the current state, shared by the processes below
	logic       timer_tick;
	logic       wr;
	logic [2:0] wave_mode_field;
	logic [7:0] top;
	logic       pwm;
	logic [1:0] match;
	logic       at_top;
	logic       at_bottom;
	logic [2:0] ack;
	logic [1:0] act_a, act_b;

	tick_select #(
		.PRESCALE_WIDTH (PRESCALE_WIDTH)
	) u_tick (
		.clk                (CLK_IN),
		.arst_n             (ARST_N_IN),
		.run                (~power_off_reg),
		.clock_select_field (control_reg_b[`FLD_CS]),
		.ext_count_pin      (EXT_COUNT_PIN_IN),
		.timer_tick         (timer_tick)
	);

	// Mode and top decode
	always_comb begin
		wave_mode_field = {control_reg_b[`BIT_WGM_HI], control_reg_a[`FLD_WGM_LO]};
		pwm = is_pwm(wave_mode_field);
		top = wave_mode_field[2] ? compare_a_reg : `COUNT_MAX;
		at_top    = (count_reg == top);
		at_bottom = (count_reg == `COUNT_BOTTOM);
		match[0]  = (count_reg == compare_a_reg) && !block_reg;
		match[1]  = (count_reg == compare_b_reg) && !block_reg;
		act_a = control_reg_a[`FLD_ACT_A];
		act_b = control_reg_a[`FLD_ACT_B];
		ack = {ACK_MATCH_B_IN, ACK_MATCH_A_IN, ACK_OVF_IN};
		wr  = WRITE_IN && (bus_reg == timer_unit_zero_pkg::BUS_IDLE);
	end

	// Bus handshake: writes take one wait-free cycle, reads two wait cycles
	always_comb begin
		bus_next = timer_unit_zero_pkg::BUS_IDLE;
		case (bus_reg)
			timer_unit_zero_pkg::BUS_IDLE:
				bus_next = READ_IN ? timer_unit_zero_pkg::BUS_READ
					: timer_unit_zero_pkg::BUS_IDLE;
			timer_unit_zero_pkg::BUS_READ: bus_next = timer_unit_zero_pkg::BUS_DONE;
			timer_unit_zero_pkg::BUS_DONE: bus_next = timer_unit_zero_pkg::BUS_IDLE;
			default: bus_next = timer_unit_zero_pkg::BUS_IDLE;
		endcase
	end

	// Read mux; PWM modes read the buffer, others the live compare
	always_comb begin
		rdata_next = rdata_reg;
		// Control C holds strobes only, so it reads back as zero
		if (bus_reg == timer_unit_zero_pkg::BUS_IDLE && READ_IN) begin
			case (ADDRESS_IN)
				`OFS_CONTROL_A: rdata_next = control_reg_a;
				`OFS_CONTROL_B: rdata_next = control_reg_b;
				`OFS_COUNT:     rdata_next = count_reg;
				`OFS_COMPARE_A: rdata_next = pwm ? buffer_a_reg : compare_a_reg;
				`OFS_COMPARE_B: rdata_next = pwm ? buffer_b_reg : compare_b_reg;
				`OFS_FLAG:      rdata_next = {5'h00, flag_reg};
				`OFS_MASK:      rdata_next = {5'h00, mask_reg};
				`OFS_POWER:     rdata_next = {7'h00, power_off_reg};
				default:        rdata_next = 8'h00;
			endcase
		end
	end

	// Configuration and compare registers
	always_comb begin
		control_a_next = control_reg_a;
		control_b_next = control_reg_b;
		compare_a_next = compare_a_reg;
		compare_b_next = compare_b_reg;
		buffer_a_next  = buffer_a_reg;
		buffer_b_next  = buffer_b_reg;
		mask_next      = mask_reg;
		power_off_next = power_off_reg;
		if (wr) begin
			case (ADDRESS_IN)
				`OFS_CONTROL_A: control_a_next = WRITEDATA_IN;
				`OFS_CONTROL_B: control_b_next = WRITEDATA_IN;
				`OFS_COMPARE_A: begin
					buffer_a_next = WRITEDATA_IN;
					if (!pwm)
						compare_a_next = WRITEDATA_IN;
				end
				`OFS_COMPARE_B: begin
					buffer_b_next = WRITEDATA_IN;
					if (!pwm)
						compare_b_next = WRITEDATA_IN;
				end
				`OFS_MASK:  mask_next = WRITEDATA_IN[2:0];
				`OFS_POWER: power_off_next = WRITEDATA_IN[`BIT_POWER_OFF];
				default: ;
			endcase
		end
		// Buffer copy only on a tick at top, so a period never mixes two values
		// Both slopes pass top once per period, which keeps fast and phase alike
		if (pwm && timer_tick && !power_off_reg) begin
			if (at_top) begin
				compare_a_next = buffer_a_next;
				compare_b_next = buffer_b_next;
			end
		end
	end

	// Counter, direction and match blocking
	always_comb begin
		count_next = count_reg;
		down_next  = down_reg;
		block_next = block_reg;
		if (timer_tick) begin
			block_next = 1'b0;
			case (wave_mode_field)
				`WGM_NORMAL: count_next = count_reg + 8'h01;
				`WGM_CTC: count_next = match[0] || (count_reg == compare_a_reg)
					? `COUNT_BOTTOM : count_reg + 8'h01;
				`WGM_FAST_MAX, `WGM_FAST_A: count_next = at_top
					? `COUNT_BOTTOM : count_reg + 8'h01;
				// Dual slope turns at top and bottom; down_reg keeps the direction
				`WGM_PHASE_MAX, `WGM_PHASE_A: begin
					if (down_reg && at_bottom) begin
						down_next  = 1'b0;
						count_next = count_reg + 8'h01;
					end else if (!down_reg && at_top) begin
						down_next  = 1'b1;
						count_next = count_reg - 8'h01;
					end else begin
						count_next = down_reg ? count_reg - 8'h01 : count_reg + 8'h01;
					end
				end
				default: count_next = count_reg + 8'h01;
			endcase
		end
		// Bus write comes last so it beats any clear or count in the same cycle
		if (wr && ADDRESS_IN == `OFS_COUNT) begin
			count_next = WRITEDATA_IN;
			block_next = 1'b1;
		end
	end

	// Flags: hardware set wins over software or acknowledge clear
	always_comb begin
		flag_next = flag_reg;
		if (wr && ADDRESS_IN == `OFS_FLAG)
			flag_next = flag_next & ~WRITEDATA_IN[2:0];
		flag_next = flag_next & ~ack;
		if (timer_tick) begin
			if (count_reg == `COUNT_MAX && count_next == `COUNT_BOTTOM)
				flag_next[`BIT_OVF] = 1'b1;
			if (pwm && wave_mode_field[1] == 1'b0 && at_bottom)
				flag_next[`BIT_OVF] = 1'b1;
			if (match[0])
				flag_next[`BIT_MATCH_A] = 1'b1;
			if (match[1])
				flag_next[`BIT_MATCH_B] = 1'b1;
		end
		// Request follows the stored flag, one cycle behind it
		irq_next = flag_reg & mask_reg;
	end

	// Output states; kept across mode changes, forced in non-PWM modes
	always_comb begin
		logic [1:0] ra;
		logic [1:0] rb;
		ra = out_action(act_a, state_reg[0]);
		rb = out_action(act_b, state_reg[1]);
		state_next = state_reg;
		// A force write wins over a match in the same cycle
		if (!pwm && wr && ADDRESS_IN == `OFS_CONTROL_C) begin
			if (WRITEDATA_IN[`BIT_FORCE_A])
				state_next[0] = ra[0];
			if (WRITEDATA_IN[`BIT_FORCE_B])
				state_next[1] = rb[0];
		end else if (timer_tick && !pwm) begin
			if (match[0])
				state_next[0] = ra[0];
			if (match[1])
				state_next[1] = rb[0];
		end else if (timer_tick && pwm) begin
			// Non-inverting clears on match and sets at bottom, inverting the reverse
			if (act_a[1] && match[0])
				state_next[0] = ~act_a[0] ? 1'b0 : 1'b1;
			else if (act_a[1] && count_next == `COUNT_BOTTOM)
				state_next[0] = act_a[0] ? 1'b0 : 1'b1;
			if (act_b[1] && match[1])
				state_next[1] = ~act_b[0] ? 1'b0 : 1'b1;
			else if (act_b[1] && count_next == `COUNT_BOTTOM)
				state_next[1] = act_b[0] ? 1'b0 : 1'b1;
		end
	end

	// All state registers
	always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			bus_reg       <= timer_unit_zero_pkg::BUS_IDLE;
			control_reg_a <= `RESET_BYTE;
			control_reg_b <= `RESET_BYTE;
			count_reg     <= `RESET_BYTE;
			compare_a_reg <= `RESET_BYTE;
			compare_b_reg <= `RESET_BYTE;
			buffer_a_reg  <= `RESET_BYTE;
			buffer_b_reg  <= `RESET_BYTE;
			flag_reg      <= 3'h0;
			mask_reg      <= 3'h0;
			power_off_reg <= 1'b0;
			state_reg     <= 2'h0;
			block_reg     <= 1'b0;
			down_reg      <= 1'b0;
			rdata_reg     <= 8'h00;
			irq_reg       <= 3'h0;
		end else begin
			bus_reg       <= bus_next;
			control_reg_a <= control_a_next;
			control_reg_b <= control_b_next;
			count_reg     <= count_next;
			compare_a_reg <= compare_a_next;
			compare_b_reg <= compare_b_next;
			buffer_a_reg  <= buffer_a_next;
			buffer_b_reg  <= buffer_b_next;
			flag_reg      <= flag_next;
			mask_reg      <= mask_next;
			power_off_reg <= power_off_next;
			state_reg     <= state_next;
			block_reg     <= block_next;
			down_reg      <= down_next;
			rdata_reg     <= rdata_next;
			irq_reg       <= irq_next;
		end
	end

	// Outputs straight from flip-flops, except the decoded wait
	always_comb begin
		READDATA_OUT      = rdata_reg;
		// Wait is decoded, not stored, so writes complete without a wait cycle
		WAITREQUEST_OUT   = READ_IN && bus_reg != timer_unit_zero_pkg::BUS_DONE;
		COMPARE_OUT_A_OUT = state_reg[0];
		COMPARE_OUT_B_OUT = state_reg[1];
		IRQ_OVF_OUT       = irq_reg[0];
		IRQ_MATCH_A_OUT   = irq_reg[1];
		IRQ_MATCH_B_OUT   = irq_reg[2];
	end
endmodule

// [verif/timer_unit_zero_assertions.sv]
// Port-level property checker for the timer unit
`timescale 1ns/100ps

module timer_unit_zero_assertions (
	// Clock and reset
	input  wire logic       CLK_IN,
	input  wire logic       ARST_N_IN,
	// Register bus
	input  wire logic       READ_IN,
	input  wire logic       WRITE_IN,
	input  wire logic [7:0] READDATA_OUT,
	input  wire logic       WAITREQUEST_OUT,
	// Interrupt requests and acknowledges
	input  wire logic       IRQ_OVF_OUT,
	input  wire logic       IRQ_MATCH_A_OUT,
	input  wire logic       IRQ_MATCH_B_OUT,
	input  wire logic       ACK_OVF_IN,
	input  wire logic       ACK_MATCH_A_IN,
	input  wire logic       ACK_MATCH_B_IN
);
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (!ARST_N_IN);

	// Bus handshake: writes never stall, reads answer on the third cycle
	AST_WRITE_NOWAIT: assert property (WRITE_IN |-> !WAITREQUEST_OUT)
		else $error("write stalled");
	AST_READ_WAIT: assert property ($rose(READ_IN) |-> WAITREQUEST_OUT [*2]
		##1 !WAITREQUEST_OUT)
		else $error("read answer out of step");
	AST_IDLE_NOWAIT: assert property (!READ_IN |-> !WAITREQUEST_OUT)
		else $error("wait raised while idle");
	AST_READ_STEADY: assert property (!READ_IN ##1 !READ_IN |-> $stable(READDATA_OUT))
		else $error("read data moved between reads");

	// Servicing drops the request within the registered lag
	AST_OVF_SERVICED: assert property (ACK_OVF_IN |-> ##[1:2] !IRQ_OVF_OUT)
		else $error("overflow request survived service");
	AST_A_SERVICED: assert property (ACK_MATCH_A_IN |-> ##[1:2] !IRQ_MATCH_A_OUT)
		else $error("match A request survived service");
	AST_B_SERVICED: assert property (ACK_MATCH_B_IN |-> ##[1:2] !IRQ_MATCH_B_OUT)
		else $error("match B request survived service");

	// Without a write or service the request keeps standing
	AST_A_HOLD: assert property (IRQ_MATCH_A_OUT && !$past(WRITE_IN)
		&& !$past(ACK_MATCH_A_IN) |=> IRQ_MATCH_A_OUT)
		else $error("match A request dropped alone");
endmodule

bind timer_unit_zero timer_unit_zero_assertions chk (
	.CLK_IN          (CLK_IN),
	.ARST_N_IN       (ARST_N_IN),
	.READ_IN         (READ_IN),
	.WRITE_IN        (WRITE_IN),
	.READDATA_OUT    (READDATA_OUT),
	.WAITREQUEST_OUT (WAITREQUEST_OUT),
	.IRQ_OVF_OUT     (IRQ_OVF_OUT),
	.IRQ_MATCH_A_OUT (IRQ_MATCH_A_OUT),
	.IRQ_MATCH_B_OUT (IRQ_MATCH_B_OUT),
	.ACK_OVF_IN      (ACK_OVF_IN),
	.ACK_MATCH_A_IN  (ACK_MATCH_A_IN),
	.ACK_MATCH_B_IN  (ACK_MATCH_B_IN)
);

// [verif/ext_pulse_model.sv]
// Far-side model driving the external count pin with pulse trains
`timescale 1ns/100ps

module ext_pulse_model (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       arst_n,
	// Request
	input  wire logic       go,
	input  wire logic [3:0] pulses,
	input  wire logic [3:0] half,
	// Pin and status
	output logic            pin,
	output logic            busy
);
	logic [3:0] left_reg;
	logic [3:0] tmr_reg;

	// Half period is variable so both quick and slow sources are exercised
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pin <= 1'b0;
			busy <= 1'b0;
			left_reg <= 4'h0;
			tmr_reg <= 4'h0;
		end else if (go && !busy) begin
			busy <= 1'b1;
			left_reg <= pulses;
			tmr_reg <= half;
		end else if (busy) begin
			if (tmr_reg != 4'h0) begin
				tmr_reg <= tmr_reg - 4'h1;
			end else if (pin) begin
				pin <= 1'b0;
				tmr_reg <= half;
			end else if (left_reg != 4'h0) begin
				pin <= 1'b1;
				left_reg <= left_reg - 4'h1;
				tmr_reg <= half;
			end else begin
				busy <= 1'b0;
			end
		end
	end
endmodule

// [verif/tb_top.sv]
// Self-checking testbench for the timer unit
`timescale 1ns/100ps
`include "timer_unit_zero_defs.svh"

module tb_top;
	logic       clk = 1'b0;
	logic       arst_n = 1'b0;
	logic [3:0] address = 4'h0;
	logic       rd = 1'b0;
	logic       wr = 1'b0;
	logic [7:0] wdata = 8'h00;
	logic [7:0] rdata;
	logic       waitreq;
	logic       out_a;
	logic       out_b;
	logic [2:0] irqs;
	logic [2:0] ack = 3'h0;
	logic       pin;
	logic       go = 1'b0;
	logic [3:0] pulses = 4'h0;
	logic [3:0] half = 4'h3;
	logic       busy;
	logic [7:0] seed = 8'h5e;
	logic [7:0] expq[$];
	int         errors = 0;
	int         comparisons = 0;
	int         cycles = 0;

	always #25 clk = ~clk;

	timer_unit_zero #(.PRESCALE_WIDTH(10)) uut (
		.CLK_IN(clk), .ARST_N_IN(arst_n), .ADDRESS_IN(address), .READ_IN(rd),
		.WRITE_IN(wr), .WRITEDATA_IN(wdata), .READDATA_OUT(rdata),
		.WAITREQUEST_OUT(waitreq), .EXT_COUNT_PIN_IN(pin), .COMPARE_OUT_A_OUT(out_a),
		.COMPARE_OUT_B_OUT(out_b), .IRQ_OVF_OUT(irqs[0]), .IRQ_MATCH_A_OUT(irqs[1]),
		.IRQ_MATCH_B_OUT(irqs[2]), .ACK_OVF_IN(ack[0]), .ACK_MATCH_A_IN(ack[1]),
		.ACK_MATCH_B_IN(ack[2])
	);

	ext_pulse_model far (
		.clk(clk), .arst_n(arst_n), .go(go), .pulses(pulses), .half(half),
		.pin(pin), .busy(busy)
	);

	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		comparisons++;
		if (seen !== want) begin
			errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask

	task automatic close_out;
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction

	task automatic idle(input int n);
		repeat (n) @(posedge clk);
	endtask

	// Request held until wait is seen low at an edge
	task automatic bus_write(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		address <= a;
		wdata <= d;
		wr <= 1'b1;
		do begin @(posedge clk); end while (waitreq !== 1'b0);
		wr <= 1'b0;
	endtask

	// No wait limit here: only the hang guard ends a stuck request
	task automatic bus_read(input logic [3:0] a, input logic [7:0] want);
		expq.push_back(want);
		@(posedge clk);
		address <= a;
		rd <= 1'b1;
		do begin @(posedge clk); end while (waitreq !== 1'b0);
		rd <= 1'b0;
	endtask

	task automatic ack_pulse(input logic [2:0] m);
		@(posedge clk);
		ack <= m;
		@(posedge clk);
		ack <= 3'h0;
	endtask

	task automatic wait_irq(input int i);
		int t;
		t = 0;
		while (irqs[i] !== 1'b1 && t < 600) begin @(posedge clk); t++; end
		check({7'h0, irqs[i]}, 8'h01);
	endtask

	task automatic set_clock(input logic [2:0] cs);
		bus_write(`OFS_CONTROL_B, {5'h0, cs});
	endtask

	// Pulse train on the pin while the chosen edge drives the count
	task automatic ext_run(input logic [2:0] cs, input logic [3:0] n, input logic [3:0] h);
		set_clock(cs);
		@(posedge clk);
		pulses <= n;
		half <= h;
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		do begin @(posedge clk); end while (busy !== 1'b0);
		idle(10);
		set_clock(`CS_STOPPED);
	endtask

	// Read data taken at the edge that ends the wait
	always @(posedge clk) begin
		if (rd === 1'b1 && waitreq === 1'b0 && expq.size() > 0) begin
			check(rdata, expq.pop_front());
		end
	end

	// Hang guard, far above the expected run length
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			close_out();
		end
	end

	initial begin
		repeat (6) @(posedge clk);
		arst_n <= 1'b1;
		// Reset values and an unmapped place
		for (int a = 0; a < 9; a++) bus_read(4'(a), 8'h00);
		bus_write(4'hf, 8'hff);
		bus_read(4'hf, 8'h00);
		// Stopped counter keeps a random written value
		seed = lfsr(seed);
		bus_write(`OFS_COUNT, seed);
		idle(20);
		bus_read(`OFS_COUNT, seed);
		// Wrap from max raises overflow, compares kept out of reach
		bus_write(`OFS_COMPARE_A, 8'h80);
		bus_write(`OFS_COMPARE_B, 8'h80);
		bus_read(`OFS_COMPARE_A, 8'h80);
		bus_write(`OFS_COUNT, `COUNT_MAX - 8'h01);
		bus_write(`OFS_MASK, 8'h01);
		set_clock(`CS_DIV1);
		wait_irq(`BIT_OVF);
		set_clock(`CS_STOPPED);
		bus_read(`OFS_FLAG, 8'h01);
		ack_pulse(3'h1);
		idle(3);
		check({7'h0, irqs[0]}, 8'h00);
		// Count written onto a compare value hides that match
		bus_write(`OFS_MASK, 8'h06);
		bus_write(`OFS_COUNT, 8'h80);
		set_clock(`CS_DIV1);
		idle(5);
		set_clock(`CS_STOPPED);
		bus_read(`OFS_FLAG, 8'h00);
		bus_write(`OFS_COUNT, 8'h7e);
		set_clock(`CS_DIV1);
		wait_irq(`BIT_MATCH_A);
		set_clock(`CS_STOPPED);
		ack_pulse(3'h6);
		bus_read(`OFS_FLAG, 8'h00);
		// Random compare B, cleared by writing one
		seed = lfsr(seed);
		bus_write(`OFS_COMPARE_B, {2'h0, seed[5:0]} + 8'h10);
		bus_write(`OFS_COUNT, 8'h00);
		set_clock(`CS_DIV1);
		wait_irq(`BIT_MATCH_B);
		set_clock(`CS_STOPPED);
		bus_read(`OFS_FLAG, 8'h04);
		bus_write(`OFS_FLAG, 8'h04);
		bus_read(`OFS_FLAG, 8'h00);
		check({6'h0, out_b, out_a}, 8'h00);
		// Clear-on-match never lets the count reach max
		bus_write(`OFS_MASK, 8'h00);
		bus_write(`OFS_CONTROL_A, {5'h0, `WGM_CTC});
		bus_write(`OFS_COMPARE_A, 8'h03);
		bus_write(`OFS_COUNT, 8'h00);
		set_clock(`CS_DIV1);
		idle(600);
		set_clock(`CS_STOPPED);
		bus_read(`OFS_FLAG, 8'h02);
		bus_write(`OFS_FLAG, 8'h07);
		// Forced match: A toggles, B sets, flags and count untouched
		bus_write(`OFS_COUNT, 8'h21);
		bus_write(`OFS_CONTROL_A, 8'h70);
		bus_write(`OFS_CONTROL_C, 8'hc0);
		idle(3);
		check({6'h0, out_b, out_a}, 8'h03);
		bus_read(`OFS_COUNT, 8'h21);
		bus_read(`OFS_FLAG, 8'h00);
		bus_read(`OFS_CONTROL_C, 8'h00);
		// Mode change leaves the output states alone
		bus_write(`OFS_CONTROL_A, 8'h73);
		idle(3);
		check({6'h0, out_b, out_a}, 8'h03);
		bus_write(`OFS_CONTROL_A, 8'h00);
		// Power-off bit freezes the count
		bus_write(`OFS_POWER, 8'h01);
		set_clock(`CS_DIV1);
		idle(20);
		set_clock(`CS_STOPPED);
		bus_read(`OFS_COUNT, 8'h21);
		bus_write(`OFS_POWER, 8'h00);
		// Fast PWM: compare writes wait in the buffer until the count passes top
		bus_write(`OFS_CONTROL_A, 8'h03);
		bus_write(`OFS_COMPARE_A, 8'h10);
		bus_read(`OFS_COMPARE_A, 8'h10);
		bus_write(`OFS_CONTROL_A, 8'h00);
		bus_read(`OFS_COMPARE_A, 8'h03);
		bus_write(`OFS_CONTROL_A, 8'h03);
		bus_write(`OFS_COUNT, 8'hfe);
		set_clock(`CS_DIV1);
		idle(4);
		set_clock(`CS_STOPPED);
		bus_read(`OFS_COUNT, 8'h04);
		bus_write(`OFS_CONTROL_A, 8'h00);
		bus_read(`OFS_COMPARE_A, 8'h10);
		// Phase correct: six ticks from 0xfd turn at 0xff and come down
		bus_write(`OFS_CONTROL_A, 8'h01);
		bus_write(`OFS_COUNT, 8'hfd);
		set_clock(`CS_DIV1);
		idle(4);
		set_clock(`CS_STOPPED);
		bus_read(`OFS_COUNT, 8'hfb);
		bus_write(`OFS_CONTROL_A, 8'h00);
		// Pin edges: rising with quick pulses, falling with slow ones
		bus_write(`OFS_COUNT, 8'h00);
		ext_run(`CS_EXT_RISE, 4'h5, 4'h3);
		bus_read(`OFS_COUNT, 8'h05);
		ext_run(`CS_EXT_FALL, 4'h4, 4'h6);
		bus_read(`OFS_COUNT, 8'h09);
		idle(2);
		close_out();
	end
endmodule
